/* File: rtl/pfd_map.svh */
// Address map, frame codes and reset values of the peripheral file decoder
`ifndef PFD_MAP_SVH
`define PFD_MAP_SVH

`define PFD_ADDR_W 16
`define PFD_PF_TOP 16'h01FF
`define PFD_WORD_BIT 8
`define PFD_FRAME_HI 7
`define PFD_FRAME_LO 4
`define PFD_SFR_HI 3
`define PFD_SFR_LO 0
`define PFD_NFRAMES 16

`define PFD_WFRM_WDT 4'h2
`define PFD_WFRM_MUL 4'h3
`define PFD_WFRM_CNV0 4'h4
`define PFD_WFRM_CNV1 4'h5
`define PFD_WFRM_TMA0 4'h6
`define PFD_WFRM_TMB1 4'h9
`define PFD_WFRM_CCTL 4'hA

`define PFD_BFRM_SFR 4'h0
`define PFD_BFRM_P34 4'h1
`define PFD_BFRM_P12 4'h2
`define PFD_BFRM_P56 4'h3
`define PFD_BFRM_CLK 4'h5
`define PFD_BFRM_SER 4'h7
`define PFD_BFRM_CMEM 4'h8

`define PFD_SFR_IE1 4'h0
`define PFD_SFR_IE2 4'h1
`define PFD_SFR_INTERRUPT_FLAGS_FIRST 4'h2
`define PFD_SFR_INTERRUPT_FLAGS_SECOND 4'h3
`define PFD_SFR_ME1 4'h4
`define PFD_SFR_ME2 4'h5
`define PFD_SFR_LAST 4'h5

`define PFD_SFR_RST 8'h00
`define PFD_HI_ZERO 8'h00
`define PFD_WORD_ZERO 16'h0000

`endif

/* File: rtl/pfd_pkg.sv */
// Types shared by the peripheral file decoder modules
package pfd_pkg;

	typedef enum logic [1:0]
	{
		PFD_REG_NONE,
		PFD_REG_WORD,
		PFD_REG_BYTE
	} pfd_region_type;

	typedef struct packed
	{
		logic [7:0] ie1;
		logic [7:0] ie2;
		logic [7:0] interrupt_flags_first;
		logic [7:0] interrupt_flags_second;
		logic [7:0] me1;
		logic [7:0] me2;
		logic [7:0] rdata;
	} pfd_sfr_state_type;

endpackage

/* File: rtl/pfd_sfr_if.sv */
// Carrier between the decoder and its special function register bank
`timescale 1ns/1ps
interface pfd_sfr_if;
	logic sel;
	logic wr;
	logic [3:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [15:0] ifg_set;
	logic [7:0] ie1;
	logic [7:0] ie2;
	logic [7:0] interrupt_flags_first;
	logic [7:0] interrupt_flags_second;
	logic [7:0] me1;
	logic [7:0] me2;

	modport dec
	(
		output sel,
		output wr,
		output idx,
		output wdata,
		output ifg_set,
		input rdata,
		input ie1,
		input ie2,
		input interrupt_flags_first,
		input interrupt_flags_second,
		input me1,
		input me2
	);

	modport bank
	(
		input sel,
		input wr,
		input idx,
		input wdata,
		input ifg_set,
		output rdata,
		output ie1,
		output ie2,
		output interrupt_flags_first,
		output interrupt_flags_second,
		output me1,
		output me2
	);
endinterface

/* File: rtl/pfd_sfr_bank.sv */
// Byte-wide interrupt enable, interrupt flag and module enable registers
`timescale 1ns/1ps
`include "pfd_map.svh"
module pfd_sfr_bank
(
	input wire logic clk_i,
	input wire logic srst_i,
	pfd_sfr_if.bank sfr
);

	pfd_pkg::pfd_sfr_state_type state_reg;
	pfd_pkg::pfd_sfr_state_type state_next;

	always_comb
	begin
		state_next = state_reg;
		state_next.rdata = `PFD_SFR_RST;
		if (sfr.sel && sfr.wr)
		begin
			unique case (sfr.idx)
				`PFD_SFR_IE1: state_next.ie1 = sfr.wdata;
				`PFD_SFR_IE2: state_next.ie2 = sfr.wdata;
				`PFD_SFR_INTERRUPT_FLAGS_FIRST: state_next.interrupt_flags_first = sfr.wdata;
				`PFD_SFR_INTERRUPT_FLAGS_SECOND: state_next.interrupt_flags_second = sfr.wdata;
				`PFD_SFR_ME1: state_next.me1 = sfr.wdata;
				`PFD_SFR_ME2: state_next.me2 = sfr.wdata;
				default: ;
			endcase
		end
		// Hardware set wins over software clear
		state_next.interrupt_flags_first = state_next.interrupt_flags_first | sfr.ifg_set[7:0];
		state_next.interrupt_flags_second = state_next.interrupt_flags_second | sfr.ifg_set[15:8];
		if (sfr.sel && !sfr.wr)
		begin
			unique case (sfr.idx)
				`PFD_SFR_IE1: state_next.rdata = state_reg.ie1;
				`PFD_SFR_IE2: state_next.rdata = state_reg.ie2;
				`PFD_SFR_INTERRUPT_FLAGS_FIRST: state_next.rdata = state_reg.interrupt_flags_first;
				`PFD_SFR_INTERRUPT_FLAGS_SECOND: state_next.rdata = state_reg.interrupt_flags_second;
				`PFD_SFR_ME1: state_next.rdata = state_reg.me1;
				`PFD_SFR_ME2: state_next.rdata = state_reg.me2;
				default: state_next.rdata = `PFD_SFR_RST;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign sfr.rdata = state_reg.rdata;
	assign sfr.ie1 = state_reg.ie1;
	assign sfr.ie2 = state_reg.ie2;
	assign sfr.interrupt_flags_first = state_reg.interrupt_flags_first;
	assign sfr.interrupt_flags_second = state_reg.interrupt_flags_second;
	assign sfr.me1 = state_reg.me1;
	assign sfr.me2 = state_reg.me2;

endmodule

/* File: rtl/pfd_frame_dec.sv */
// One-hot frame select decoder for a sixteen-frame region
`timescale 1ns/1ps
`include "pfd_map.svh"
module pfd_frame_dec
(
	input wire logic en_i,
	input wire logic [3:0] frame_i,
	input wire logic [15:0] impl_i,
	output logic [15:0] sel_o
);

	genvar g;
	generate
		for (g = 0; g < `PFD_NFRAMES; g++)
		begin : g_frame
			assign sel_o[g] = en_i && impl_i[g] && (frame_i == 4'(g));
		end
	endgenerate

endmodule

/* File: rtl/pfd_decoder.sv */
// Peripheral file access decoder between the core and the peripherals
`timescale 1ns/1ps
`include "pfd_map.svh"

module pfd_decoder
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic req_i,
	input wire logic wr_i,
	input wire logic byte_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o,
	output logic rvalid_o,
	output logic [15:0] word_sel_o,
	output logic [15:0] byte_sel_o,
	output logic per_wr_o,
	output logic per_byte_o,
	output logic [7:0] per_addr_o,
	output logic [15:0] per_wdata_o,
	input wire logic [15:0] word_rdata_i,
	input wire logic [7:0] byte_rdata_i,
	input wire logic [15:0] ifg_set_i,
	output logic [7:0] ie1_o,
	output logic [7:0] ie2_o,
	output logic [7:0] interrupt_flags_first_o,
	output logic [7:0] interrupt_flags_second_o,
	output logic [15:0] mod_en_o
);

	typedef struct packed
	{
		logic [15:0] word_sel;
		logic [15:0] byte_sel;
		logic per_wr;
		logic per_byte;
		logic [7:0] per_addr;
		logic [15:0] per_wdata;
		logic rd_pend;
		pfd_pkg::pfd_region_type rd_reg;
		logic rd_byte;
		logic rd_sfr;
		logic [15:0] rdata;
		logic rvalid;
	} pfd_dec_state_type;

	localparam logic [15:0] WORD_IMPL = 16'h07FC;
	localparam logic [15:0] BYTE_IMPL = 16'h01AF;

	pfd_dec_state_type state_reg;
	pfd_dec_state_type state_next;
	pfd_pkg::pfd_region_type region;
	logic [15:0] word_hit;
	logic [15:0] byte_hit;
	logic sfr_hit;
	logic sfr_impl;
	logic in_pf;

	pfd_sfr_if sfr ();

	// ----------------------------------------
	// Region and frame decoding
	// ----------------------------------------
	always_comb
	begin
		in_pf = req_i && (addr_i <= `PFD_PF_TOP);
		region = pfd_pkg::PFD_REG_NONE;
		if (in_pf)
		begin
			if (addr_i[`PFD_WORD_BIT])
			begin
				region = pfd_pkg::PFD_REG_WORD;
			end
			else
			begin
				region = pfd_pkg::PFD_REG_BYTE;
			end
		end
	end

	// Word frames: watchdog, multiplier, converter, timers, control
	pfd_frame_dec u_word_dec
	(
		.en_i(region == pfd_pkg::PFD_REG_WORD),
		.frame_i(addr_i[`PFD_FRAME_HI:`PFD_FRAME_LO]),
		.impl_i(WORD_IMPL),
		.sel_o(word_hit)
	);

	// Byte frames: registers, ports, clock, serial, converter memory
	pfd_frame_dec u_byte_dec
	(
		.en_i(region == pfd_pkg::PFD_REG_BYTE),
		.frame_i(addr_i[`PFD_FRAME_HI:`PFD_FRAME_LO]),
		.impl_i(BYTE_IMPL),
		.sel_o(byte_hit)
	);

	// ----------------------------------------
	// Special function register access
	// ----------------------------------------
	always_comb
	begin
		sfr_hit = byte_hit[`PFD_BFRM_SFR];
		sfr_impl = addr_i[`PFD_SFR_HI:`PFD_SFR_LO] <= `PFD_SFR_LAST;
	end

	assign sfr.sel = sfr_hit && sfr_impl && byte_i;
	assign sfr.wr = wr_i;
	assign sfr.idx = addr_i[`PFD_SFR_HI:`PFD_SFR_LO];
	assign sfr.wdata = wdata_i[7:0];
	assign sfr.ifg_set = ifg_set_i;

	pfd_sfr_bank u_sfr
	(
		.clk_i(clk_i),
		.srst_i(srst_i),
		.sfr(sfr)
	);

	// ----------------------------------------
	// Access sequencing and width adaptation
	// ----------------------------------------
	always_comb
	begin
		state_next = state_reg;
		state_next.word_sel = `PFD_WORD_ZERO;
		state_next.byte_sel = `PFD_WORD_ZERO;
		state_next.per_wr = 1'b0;
		state_next.rd_pend = 1'b0;
		state_next.rvalid = 1'b0;
		if (region == pfd_pkg::PFD_REG_WORD)
		begin
			// Odd byte access to word modules is not allowed
			if (!(byte_i && addr_i[0]))
			begin
				state_next.word_sel = word_hit;
			end
			state_next.per_wdata = wdata_i;
		end
		else if (region == pfd_pkg::PFD_REG_BYTE)
		begin
			if (!sfr_hit)
			begin
				state_next.byte_sel = byte_hit;
			end
			state_next.per_wdata = {`PFD_HI_ZERO, wdata_i[7:0]};
		end
		if (in_pf)
		begin
			state_next.per_wr = wr_i;
			state_next.per_byte = byte_i;
			state_next.per_addr = addr_i[7:0];
			state_next.rd_pend = !wr_i;
			state_next.rd_reg = region;
			state_next.rd_byte = byte_i;
			state_next.rd_sfr = sfr_hit;
		end
		// Read data is returned the cycle after the selects
		if (state_reg.rd_pend)
		begin
			state_next.rvalid = 1'b1;
			state_next.rdata = `PFD_WORD_ZERO;
			if (state_reg.rd_sfr)
			begin
				state_next.rdata = {`PFD_HI_ZERO, sfr.rdata};
			end
			else if (state_reg.byte_sel != `PFD_WORD_ZERO)
			begin
				// High byte passes unqualified on word reads
				state_next.rdata = state_reg.rd_byte ?
					{`PFD_HI_ZERO, byte_rdata_i} : {word_rdata_i[15:8], byte_rdata_i};
			end
			else if (state_reg.word_sel != `PFD_WORD_ZERO)
			begin
				state_next.rdata = state_reg.rd_byte ?
					{`PFD_HI_ZERO, word_rdata_i[7:0]} : word_rdata_i;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rdata_o = state_reg.rdata;
	assign rvalid_o = state_reg.rvalid;
	assign word_sel_o = state_reg.word_sel;
	assign byte_sel_o = state_reg.byte_sel;
	assign per_wr_o = state_reg.per_wr;
	assign per_byte_o = state_reg.per_byte;
	assign per_addr_o = state_reg.per_addr;
	assign per_wdata_o = state_reg.per_wdata;
	assign ie1_o = sfr.ie1;
	assign ie2_o = sfr.ie2;
	assign interrupt_flags_first_o = sfr.interrupt_flags_first;
	assign interrupt_flags_second_o = sfr.interrupt_flags_second;
	assign mod_en_o = {sfr.me2, sfr.me1};

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_word_req;
		req_i && addr_i[`PFD_WORD_BIT] && addr_i <= `PFD_PF_TOP && !(byte_i && addr_i[0]);
	endsequence

	sequence s_byte_read;
		req_i && !wr_i && byte_i && addr_i <= `PFD_PF_TOP;
	endsequence

	property p_word_region;
		@(posedge clk_i) disable iff (srst_i)
		s_word_req |=> (byte_sel_o == `PFD_WORD_ZERO)
			&& (word_sel_o == (WORD_IMPL & (16'h0001 << $past(addr_i[`PFD_FRAME_HI:`PFD_FRAME_LO]))));
	endproperty
	a_word_region: assert property (p_word_region) else $error("word select wrong");

	property p_byte_region;
		@(posedge clk_i) disable iff (srst_i)
		(req_i && !addr_i[`PFD_WORD_BIT] && addr_i <= `PFD_PF_TOP) |=> word_sel_o == 16'h0000;
	endproperty
	a_byte_region: assert property (p_byte_region) else $error("byte access hit word frame");

	property p_onehot;
		@(posedge clk_i) disable iff (srst_i)
		$onehot0({word_sel_o, byte_sel_o});
	endproperty
	a_onehot: assert property (p_onehot) else $error("more than one frame selected");

	property p_word_byte_read;
		@(posedge clk_i) disable iff (srst_i)
		(s_byte_read ##0 addr_i[`PFD_WORD_BIT]) |=> ##1 rvalid_o && rdata_o[15:8] == 8'h00;
	endproperty
	a_word_byte_read: assert property (p_word_byte_read) else $error("high byte not zero");

	property p_low_byte_wr;
		@(posedge clk_i) disable iff (srst_i)
		(req_i && wr_i && !addr_i[`PFD_WORD_BIT] && addr_i <= `PFD_PF_TOP)
			|=> per_wdata_o[15:8] == 8'h00 && per_wdata_o[7:0] == $past(wdata_i[7:0]);
	endproperty
	a_low_byte_wr: assert property (p_low_byte_wr) else $error("byte write data wrong");

	property p_reserved_zero;
		@(posedge clk_i) disable iff (srst_i)
		(req_i && !wr_i && addr_i <= `PFD_PF_TOP && addr_i[`PFD_WORD_BIT]
			&& !WORD_IMPL[addr_i[7:4]]) |=> ##1 rvalid_o && rdata_o == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved read not zero");

	property p_sfr_unimpl;
		@(posedge clk_i) disable iff (srst_i)
		(s_byte_read ##0 addr_i[7:4] == 4'h0 && addr_i[3:0] > 4'h5) |=> ##1 rdata_o == 16'h0000;
	endproperty
	a_sfr_unimpl: assert property (p_sfr_unimpl) else $error("empty register read nonzero");

	property p_me_write;
		@(posedge clk_i) disable iff (srst_i)
		(req_i && wr_i && byte_i && addr_i == 16'h0004) |=> ##1 mod_en_o[7:0] == $past(wdata_i[7:0], 2);
	endproperty
	a_me_write: assert property (p_me_write) else $error("module enable not stored");

	// ----------------------------------------
	// Width, range, answer and register checks
	// ----------------------------------------
	sequence s_read_req;
		req_i && !wr_i && addr_i <= `PFD_PF_TOP;
	endsequence

	sequence s_outside_req;
		req_i && addr_i > `PFD_PF_TOP;
	endsequence

	property p_word_wdata;
		@(posedge clk_i) disable iff (srst_i)
		(s_word_req ##0 wr_i) |=> per_wdata_o == $past(wdata_i);
	endproperty
	a_word_wdata: assert property (p_word_wdata) else $error("word write data wrong");

	property p_odd_byte;
		@(posedge clk_i) disable iff (srst_i)
		(req_i && byte_i && addr_i[0] && addr_i[`PFD_WORD_BIT] && addr_i <= `PFD_PF_TOP)
			|=> word_sel_o == `PFD_WORD_ZERO;
	endproperty
	a_odd_byte: assert property (p_odd_byte) else $error("odd byte access selected");

	property p_outside;
		@(posedge clk_i) disable iff (srst_i)
		s_outside_req |=> word_sel_o == `PFD_WORD_ZERO
			&& byte_sel_o == `PFD_WORD_ZERO && !per_wr_o;
	endproperty
	a_outside: assert property (p_outside) else $error("outside access selected");

	property p_read_answer;
		@(posedge clk_i) disable iff (srst_i)
		s_read_req |=> ##1 rvalid_o;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");

	property p_no_answer;
		@(posedge clk_i) disable iff (srst_i)
		(req_i && (wr_i || addr_i > `PFD_PF_TOP)) |=> ##1 !rvalid_o;
	endproperty
	a_no_answer: assert property (p_no_answer) else $error("write answered");

	property p_sfr_word;
		@(posedge clk_i) disable iff (srst_i)
		(req_i && !byte_i && addr_i[15:4] == 12'h000) |=> $stable({ie1_o, ie2_o, mod_en_o});
	endproperty
	a_sfr_word: assert property (p_sfr_word) else $error("word access changed register");

	property p_ie_read;
		@(posedge clk_i) disable iff (srst_i)
		(s_byte_read ##0 addr_i == 16'h0000) |=> ##1 rdata_o == {8'h00, $past(ie1_o, 2)};
	endproperty
	a_ie_read: assert property (p_ie_read) else $error("enable register read wrong");

	property p_set_wins;
		@(posedge clk_i) disable iff (srst_i)
		(ifg_set_i != 16'h0000) |=> ({interrupt_flags_second_o, interrupt_flags_first_o} & $past(ifg_set_i)) == $past(ifg_set_i);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("flag set lost");

endmodule

/* File: verif/pfd_core_model.sv */
// Processor core model issuing single-cycle byte and word accesses
`timescale 1ns/1ps
module pfd_core_model
(
	input wire logic clk_i,
	output logic req_o,
	output logic wr_o,
	output logic byte_o,
	output logic [15:0] addr_o,
	output logic [15:0] wdata_o
);
	initial
	begin
		req_o = 1'b0;
		wr_o = 1'b0;
		byte_o = 1'b0;
		addr_o = 16'h0000;
		wdata_o = 16'h0000;
	end

	// ----------------------------------------
	// One access, held for exactly one edge
	// ----------------------------------------
	// Word and byte accesses alike drive the commanded address, odd or even
	task automatic access(input logic wr, input logic bw, input logic [15:0] addr,
		input logic [15:0] data);
	begin
		@(posedge clk_i);
		#1;
		req_o = 1'b1;
		wr_o = wr;
		byte_o = bw;
		addr_o = addr;
		wdata_o = data;
		@(posedge clk_i);
		#1;
		req_o = 1'b0;
		wr_o = 1'b0;
		addr_o = ~addr;
		wdata_o = ~data;
	end
	endtask
endmodule

/* File: verif/pfd_decoder_tb.sv */
// Self-checking testbench of the peripheral file decoder
`timescale 1ns/1ps
module pfd_decoder_tb;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic req_i;
	logic wr_i;
	logic byte_i;
	logic [15:0] addr_i;
	logic [15:0] wdata_i;
	logic [15:0] rdata_o;
	logic rvalid_o;
	logic [15:0] word_sel_o;
	logic [15:0] byte_sel_o;
	logic per_wr_o;
	logic per_byte_o;
	logic [7:0] per_addr_o;
	logic [15:0] per_wdata_o;
	logic [15:0] word_rdata_i = 16'hA5C3;
	logic [7:0] byte_rdata_i = 8'h5A;
	logic [15:0] ifg_set_i = 16'h0000;
	logic [7:0] ie1_o;
	logic [7:0] ie2_o;
	logic [7:0] interrupt_flags_first_o;
	logic [7:0] interrupt_flags_second_o;
	logic [15:0] mod_en_o;
	int miscompares = 0;
	int tests_run = 0;

	always #12.5 clk_i = ~clk_i;

	pfd_core_model core (.clk_i(clk_i), .req_o(req_i), .wr_o(wr_i), .byte_o(byte_i),
		.addr_o(addr_i), .wdata_o(wdata_i));

	pfd_decoder dut (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i), .wr_i(wr_i),
		.byte_i(byte_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
		.rvalid_o(rvalid_o), .word_sel_o(word_sel_o), .byte_sel_o(byte_sel_o),
		.per_wr_o(per_wr_o), .per_byte_o(per_byte_o), .per_addr_o(per_addr_o),
		.per_wdata_o(per_wdata_o), .word_rdata_i(word_rdata_i),
		.byte_rdata_i(byte_rdata_i), .ifg_set_i(ifg_set_i), .ie1_o(ie1_o),
		.ie2_o(ie2_o), .interrupt_flags_first_o(interrupt_flags_first_o), .interrupt_flags_second_o(interrupt_flags_second_o), .mod_en_o(mod_en_o));

	// ----------------------------------------
	// Shared helpers
	// ----------------------------------------
	task automatic final_report();
	begin
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
	begin
		tests_run++;
		if (exp !== got)
		begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	end
	endtask

	task automatic rd(input logic bw, input logic [15:0] addr, output logic [15:0] d);
	begin
		core.access(1'b0, bw, addr, 16'h0000);
		@(posedge clk_i);
		#1;
		chk("rvalid", 16'h0001, {15'h0000, rvalid_o});
		d = rdata_o;
		@(posedge clk_i);
		#1;
		chk("rvalid_pulse", 16'h0000, {15'h0000, rvalid_o});
	end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_frames();
		logic [15:0] a;
	begin
		for (int n = 0; n < 16; n++)
		begin
			a = 16'h0100 + 16'(n * 16);
			core.access(1'b1, 1'b0, a, 16'hC3A5);
			chk("word_sel", (16'h0001 << n) & 16'h07FC, word_sel_o);
			chk("word_wdata", 16'hC3A5, per_wdata_o);
			chk("word_ctl", 16'h0001, {14'h0000, per_byte_o, per_wr_o});
			chk("word_addr", a & 16'h00FF, {8'h00, per_addr_o});
			a = 16'(n * 16);
			core.access(1'b1, 1'b1, a, 16'hBEEF);
			chk("byte_sel", (16'h0001 << n) & 16'h01AE, byte_sel_o);
			chk("byte_ctl", 16'h0003, {14'h0000, per_byte_o, per_wr_o});
			chk("byte_addr", a, {8'h00, per_addr_o});
			if (n != 0)
				chk("byte_wdata", 16'h00EF, per_wdata_o);
		end
		core.access(1'b1, 1'b0, 16'h0200, 16'h1111);
		chk("outside_sel", 16'h0000, word_sel_o | byte_sel_o | {15'h0000, per_wr_o});
		$display("test frames done");
	end
	endtask

	task automatic t_width();
		logic [15:0] d;
	begin
		rd(1'b0, 16'h0130, d);
		chk("word_read", 16'hA5C3, d);
		rd(1'b1, 16'h0132, d);
		chk("word_region_byte_read", 16'h00C3, d);
		core.access(1'b0, 1'b1, 16'h0133, 16'h0000);
		chk("odd_byte_sel", 16'h0000, word_sel_o);
		core.access(1'b1, 1'b0, 16'h0020, 16'h1234);
		chk("byte_region_word_write", 16'h0034, per_wdata_o);
		rd(1'b0, 16'h0020, d);
		chk("byte_region_word_read", 16'h005A, {8'h00, d[7:0]});
		rd(1'b1, 16'h01B0, d);
		chk("reserved_read", 16'h0000, d);
		$display("test width done");
	end
	endtask

	task automatic t_sfr();
		logic [15:0] d;
	begin
		chk("reset_regs", 16'h0000, {ie1_o | ie2_o | interrupt_flags_first_o | interrupt_flags_second_o, 8'h00} | mod_en_o);
		for (int i = 0; i < 6; i++)
			core.access(1'b1, 1'b1, 16'(i), 16'hFF30 + 16'(i));
		core.access(1'b1, 1'b1, 16'h0006, 16'h00FF);
		core.access(1'b1, 1'b0, 16'h0000, 16'hFFFF);
		@(posedge clk_i);
		#1;
		chk("ie", 16'h3031, {ie1_o, ie2_o});
		chk("ifg", 16'h3233, {interrupt_flags_first_o, interrupt_flags_second_o});
		chk("mod_en", 16'h3534, mod_en_o);
		for (int i = 0; i < 6; i++)
		begin
			rd(1'b1, 16'(i), d);
			chk("sfr_read", 16'h0030 + 16'(i), d);
		end
		rd(1'b1, 16'h0006, d);
		chk("unimpl_read", 16'h0000, d);
		ifg_set_i = 16'h0400;
		@(posedge clk_i);
		#1;
		ifg_set_i = 16'h0000;
		@(posedge clk_i);
		#1;
		chk("flag_set", 16'h0037, {8'h00, interrupt_flags_second_o});
		// Software clear and hardware set in the same cycle: the set wins
		fork
			core.access(1'b1, 1'b1, 16'h0003, 16'h0000);
			begin
				@(posedge clk_i);
				#1;
				ifg_set_i = 16'h0100;
				@(posedge clk_i);
				#1;
				ifg_set_i = 16'h0000;
			end
		join
		chk("set_wins", 16'h0001, {8'h00, interrupt_flags_second_o});
		core.access(1'b1, 1'b1, 16'h0005, 16'h0000);
		@(posedge clk_i);
		#1;
		chk("mod_off", 16'h0034, mod_en_o);
		$display("test sfr done");
	end
	endtask

	task automatic t_reset();
	begin
		core.access(1'b1, 1'b1, 16'h0004, 16'h00A5);
		@(posedge clk_i);
		#1;
		srst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		srst_i = 1'b0;
		chk("rerun_regs", 16'h0000, {ie1_o | ie2_o | interrupt_flags_first_o | interrupt_flags_second_o, 8'h00} | mod_en_o);
		chk("rerun_outs", 16'h0000, word_sel_o | byte_sel_o | rdata_o);
		$display("test reset done");
	end
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (2) @(posedge clk_i);
		#1;
		srst_i = 1'b0;
		t_sfr();
		t_reset();
		t_frames();
		t_width();
		final_report();
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		final_report();
	end
endmodule
